// [shared/act_regs.svh]
// Register offsets, field positions and reset values
// Assumes a Wishbone byte-lane register map, one register per word
`ifndef ACT_REGS_SVH
`define ACT_REGS_SVH
`define ACT_OFS_PREV_HI    8'h00
`define ACT_OFS_PREV_LO    8'h04
`define ACT_OFS_SUM_UP     8'h08
`define ACT_OFS_SUM_HI     8'h0c
`define ACT_OFS_SUM_LO     8'h10
`define ACT_OFS_TGT_HI     8'h14
`define ACT_OFS_TGT_LO     8'h18
`define ACT_OFS_DEV_HI     8'h1c
`define ACT_OFS_DEV_LO     8'h20
`define ACT_OFS_LOW_HI     8'h24
`define ACT_OFS_LOW_LO     8'h28
`define ACT_OFS_HIGH_HI    8'h2c
`define ACT_OFS_HIGH_LO    8'h30
`define ACT_OFS_CTRL       8'h34
`define ACT_OFS_STAT       8'h38
`define ACT_CTRL_PSIS      7
`define ACT_CTRL_JUST      6
`define ACT_CTRL_CALC_LSB  3
`define ACT_CTRL_TMD_LSB   0
`define ACT_STAT_ABOVE     6
`define ACT_STAT_BELOW     5
`define ACT_RST_BYTE       8'h00
`define ACT_RST_WORD       16'h0000
`endif

// [shared/act_pkg.sv]
// Types shared by the threshold block and its helpers
// Assumes the constants header is compiled alongside
package act_pkg;
   // Deviation calculation encodings
   typedef enum logic [2:0] {
      ACT_CALC_FIRST,    // Result minus previous value
      ACT_CALC_SECOND,   // Result minus target value
      ACT_CALC_FILT,     // Filter minus target value
      ACT_CALC_PREVF,    // Previous minus filter output
      ACT_CALC_R4, ACT_CALC_R5, ACT_CALC_R6, ACT_CALC_R7
   } act_calc_t;
   // Threshold interrupt mode encodings
   typedef enum logic [2:0] {
      ACT_TMD_NEVER,      // No request
      ACT_TMD_BELOW,      // Below low limit
      ACT_TMD_ABOVE_OR_EQ,// Not below low limit
      ACT_TMD_OUTSIDE,    // Below low or above high
      ACT_TMD_INSIDE,     // Within both limits
      ACT_TMD_NOT_ABOVE,  // Not above high limit
      ACT_TMD_ABOVE,      // Above high limit
      ACT_TMD_ALWAYS      // Every check
   } act_tmd_t;
endpackage : act_pkg

// [shared/act_cmp_if.sv]
// Carries the deviation and comparison outcome between modules
// Assumes one clock domain
`timescale 1ns/1ns
interface act_cmp_if;
   logic signed [15:0] deviation;   // Signed deviation value
   logic signed [15:0] low_limit;   // Lower limit
   logic signed [15:0] high_limit;  // Upper limit
   logic               above;       // Deviation above high limit
   logic               below;       // Deviation below low limit
   modport ctl (output deviation, low_limit, high_limit,
                input above, below);
   modport cmp (input deviation, low_limit, high_limit,
                output above, below);
endinterface : act_cmp_if

// [src/act_compare.sv]
// Signed limit comparator
// Assumes inputs held stable by the register block
`timescale 1ns/1ns
module act_compare
   import act_pkg::*;
(
   act_cmp_if.cmp cmp_io
);
   // Signed comparisons of deviation against limits
   always_comb begin
      cmp_io.above = cmp_io.deviation > cmp_io.high_limit;
      cmp_io.below = cmp_io.deviation < cmp_io.low_limit;
   end
endmodule // act_compare

// [src/act_justify.sv]
// Places a 12-bit result into a byte pair
// Assumes pure combinational use
`timescale 1ns/1ns
module act_justify
   import act_pkg::*;
#(
   parameter int RES_W = 12
)(
   input  wire logic [RES_W-1:0] result,
   input  wire logic             right_just,
   output logic      [15:0]      pair
);
   // Top alignment needs at least one pad bit
   if (RES_W >= 16) begin : g_bad_width
      $error("result must be narrower than pair");
   end
   // Top-aligned when clear, right-aligned when set
   always_comb begin
      if (right_just) begin
         pair = 16'(result);
      end else begin
         pair = {result, (16 - RES_W)'(0)};
      end
   end
endmodule // act_justify

// [src/act_threshold.sv]
// Result processing back end with Wishbone byte registers
// Assumes conversion start, result, filter value come from the front end
//
// The Wishbone register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "act_regs.svh"
module act_threshold
   import act_pkg::*;
#(
   parameter int RES_W = 12,
   parameter int SUM_W = 18
)(
   input  wire logic             SYS_CLK,
   input  wire logic             RST,
   input  wire logic             WB_CYC_I,
   input  wire logic             WB_STB_I,
   input  wire logic             WB_WE_I,
   input  wire logic [7:0]       WB_ADR_I,
   input  wire logic [3:0]       WB_SEL_I,
   input  wire logic [31:0]      WB_DAT_I,
   output logic      [31:0]      WB_DAT_O,
   output logic                  WB_ACK_O,
   input  wire logic             CONV_START,
   input  wire logic             CHECK_STROBE,
   input  wire logic [RES_W-1:0] CONV_RESULT,
   input  wire logic             LPF_MODE,
   input  wire logic [15:0]      LPF_VALUE,
   input  wire logic [2:0]       SHIFT_AMT,
   input  wire logic             SUM_LOAD,
   input  wire logic [SUM_W-1:0] SUM_IN,
   output logic                  THRESH_IRQ,
   output logic [15:0]           FILTER_OUTPUT
);
   // Widths the byte map is laid out for
   if (SUM_W != 18) begin : g_bad_sum
      $error("sum width must be 18");
   end
   if (RES_W != 12) begin : g_bad_res
      $error("result width must be 12");
   end

   // Register state
   logic [15:0]      prev_q, prev_d;       // Previous value pair
   logic [SUM_W-1:0] sum_q, sum_d;         // Running sum
   logic [15:0]      tgt_q, tgt_d;         // Target value
   logic [15:0]      low_q, low_d;         // Low limit
   logic [15:0]      high_q, high_d;       // High limit
   logic [15:0]      dev_q, dev_d;         // Deviation
   logic [7:0]       ctrl_q, ctrl_d;       // Control byte
   logic             above_q, above_d;     // Above-high flag
   logic             below_q, below_d;     // Below-low flag
   logic             irq_q, irq_d;         // Threshold request
   logic             ack_q, ack_d;         // Bus acknowledge
   logic [31:0]      rdat_q, rdat_d;       // Read data
   logic [15:0]      filt_q, filt_d;       // Filter output
   logic [15:0]      res_pair;             // Justified result
   logic             wr_en;                // Bus write this cycle
   act_calc_t        calc;                 // Deviation select
   act_tmd_t         tmd;                  // Interrupt mode

   act_cmp_if cmp_bus ();

   // Byte of write data on lane zero, if enabled
   function automatic logic [7:0] wb_byte(input logic [7:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] sel);
      return sel[0] ? d[7:0] : old;
   endfunction

   act_justify #(.RES_W(RES_W)) u_just (
      .result     (CONV_RESULT),
      .right_just (ctrl_q[`ACT_CTRL_JUST]),
      .pair       (res_pair)
   );

   act_compare u_cmp (
      .cmp_io (cmp_bus.cmp)
   );

   assign calc = act_calc_t'(ctrl_q[`ACT_CTRL_CALC_LSB +: 3]);
   assign tmd  = act_tmd_t'(ctrl_q[`ACT_CTRL_TMD_LSB +: 3]);
   // Write lands at the edge where the master samples ack high
   assign wr_en = WB_CYC_I && WB_STB_I && WB_WE_I && ack_q;
   assign cmp_bus.deviation  = dev_q;
   assign cmp_bus.low_limit  = low_q;
   assign cmp_bus.high_limit = high_q;

   // Filter output, deviation and capture next values
   always_comb begin
      logic [SUM_W-1:0] shifted;
      shifted = sum_q >> SHIFT_AMT;
      filt_d  = LPF_MODE ? LPF_VALUE : shifted[15:0];
      prev_d  = prev_q;
      if (CONV_START) begin
         if (ctrl_q[`ACT_CTRL_PSIS]) begin
            prev_d = filt_q;
         end else begin
            prev_d = res_pair;
         end
      end
      unique case (calc)
         ACT_CALC_FIRST:  dev_d = res_pair - prev_q;
         ACT_CALC_SECOND: dev_d = res_pair - tgt_q;
         ACT_CALC_FILT:   dev_d = filt_q - tgt_q;
         ACT_CALC_PREVF:  dev_d = prev_q - filt_q;
         default:         dev_d = filt_q - tgt_q;      // Reserved codes
      endcase
   end

   // Software-writable registers
   always_comb begin
      sum_d  = SUM_LOAD ? SUM_IN : sum_q;
      tgt_d  = tgt_q;
      low_d  = low_q;
      high_d = high_q;
      ctrl_d = ctrl_q;
      if (wr_en) begin
         unique case (WB_ADR_I)
            `ACT_OFS_SUM_UP:  sum_d[17:16] =
               WB_SEL_I[0] ? WB_DAT_I[1:0] : sum_q[17:16];
            `ACT_OFS_SUM_HI:  sum_d[15:8] =
               wb_byte(sum_q[15:8], WB_DAT_I, WB_SEL_I);
            `ACT_OFS_SUM_LO:  sum_d[7:0] =
               wb_byte(sum_q[7:0], WB_DAT_I, WB_SEL_I);
            `ACT_OFS_TGT_HI:  tgt_d[15:8] =
               wb_byte(tgt_q[15:8], WB_DAT_I, WB_SEL_I);
            `ACT_OFS_TGT_LO:  tgt_d[7:0] =
               wb_byte(tgt_q[7:0], WB_DAT_I, WB_SEL_I);
            `ACT_OFS_LOW_HI:  low_d[15:8] =
               wb_byte(low_q[15:8], WB_DAT_I, WB_SEL_I);
            `ACT_OFS_LOW_LO:  low_d[7:0] =
               wb_byte(low_q[7:0], WB_DAT_I, WB_SEL_I);
            `ACT_OFS_HIGH_HI: high_d[15:8] =
               wb_byte(high_q[15:8], WB_DAT_I, WB_SEL_I);
            `ACT_OFS_HIGH_LO: high_d[7:0] =
               wb_byte(high_q[7:0], WB_DAT_I, WB_SEL_I);
            `ACT_OFS_CTRL:    ctrl_d = wb_byte(ctrl_q, WB_DAT_I, WB_SEL_I);
            default: ;                              // Read-only or unmapped
         endcase
      end
   end

   // Flags and threshold request on each check strobe
   always_comb begin
      above_d = above_q;
      below_d = below_q;
      irq_d   = 1'b0;
      if (CHECK_STROBE) begin
         above_d = cmp_bus.above;
         below_d = cmp_bus.below;
         unique case (tmd)
            ACT_TMD_NEVER:       irq_d = 1'b0;
            ACT_TMD_BELOW:       irq_d = cmp_bus.below;
            ACT_TMD_ABOVE_OR_EQ: irq_d = !cmp_bus.below;
            ACT_TMD_OUTSIDE:     irq_d = cmp_bus.below || cmp_bus.above;
            ACT_TMD_INSIDE:      irq_d = !cmp_bus.below && !cmp_bus.above;
            ACT_TMD_NOT_ABOVE:   irq_d = !cmp_bus.above;
            ACT_TMD_ABOVE:       irq_d = cmp_bus.above;
            ACT_TMD_ALWAYS:      irq_d = 1'b1;
         endcase
      end
   end

   // Bus answer: one-cycle ack, read data sampled with it
   always_comb begin
      ack_d  = WB_CYC_I && WB_STB_I && !ack_q;
      rdat_d = 32'h0000_0000;
      unique case (WB_ADR_I)
         `ACT_OFS_PREV_HI: rdat_d[7:0] = prev_q[15:8];
         `ACT_OFS_PREV_LO: rdat_d[7:0] = prev_q[7:0];
         `ACT_OFS_SUM_UP:  rdat_d[7:0] = {6'h00, sum_q[17:16]};
         `ACT_OFS_SUM_HI:  rdat_d[7:0] = sum_q[15:8];
         `ACT_OFS_SUM_LO:  rdat_d[7:0] = sum_q[7:0];
         `ACT_OFS_TGT_HI:  rdat_d[7:0] = tgt_q[15:8];
         `ACT_OFS_TGT_LO:  rdat_d[7:0] = tgt_q[7:0];
         `ACT_OFS_DEV_HI:  rdat_d[7:0] = dev_q[15:8];
         `ACT_OFS_DEV_LO:  rdat_d[7:0] = dev_q[7:0];
         `ACT_OFS_LOW_HI:  rdat_d[7:0] = low_q[15:8];
         `ACT_OFS_LOW_LO:  rdat_d[7:0] = low_q[7:0];
         `ACT_OFS_HIGH_HI: rdat_d[7:0] = high_q[15:8];
         `ACT_OFS_HIGH_LO: rdat_d[7:0] = high_q[7:0];
         `ACT_OFS_CTRL:    rdat_d[7:0] = ctrl_q;
         `ACT_OFS_STAT: begin
            rdat_d[`ACT_STAT_ABOVE] = above_q;
            rdat_d[`ACT_STAT_BELOW] = below_q;
         end
         default:          rdat_d = 32'h0000_0000;  // Unmapped reads zero
      endcase
   end

   // Sum has no defined reset value
   always_ff @(posedge SYS_CLK) begin
      sum_q <= sum_d;
   end

   // Remaining state registers
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         prev_q  <= `ACT_RST_WORD;
         tgt_q   <= `ACT_RST_WORD;
         low_q   <= `ACT_RST_WORD;
         high_q  <= `ACT_RST_WORD;
         dev_q   <= `ACT_RST_WORD;
         filt_q  <= `ACT_RST_WORD;
         ctrl_q  <= `ACT_RST_BYTE;
         above_q <= 1'b0;
         below_q <= 1'b0;
         irq_q   <= 1'b0;
         ack_q   <= 1'b0;
         rdat_q  <= 32'h0000_0000;
      end else begin
         prev_q  <= prev_d;
         tgt_q   <= tgt_d;
         low_q   <= low_d;
         high_q  <= high_d;
         dev_q   <= dev_d;
         filt_q  <= filt_d;
         ctrl_q  <= ctrl_d;
         above_q <= above_d;
         below_q <= below_d;
         irq_q   <= irq_d;
         ack_q   <= ack_d;
         rdat_q  <= rdat_d;
      end
   end

   assign WB_ACK_O      = ack_q;
   assign WB_DAT_O      = rdat_q;
   assign THRESH_IRQ    = irq_q;
   assign FILTER_OUTPUT = filt_q;

   // Assertions
   property p_cap_filt;
      @(posedge SYS_CLK) disable iff (RST)
      CONV_START && ctrl_q[`ACT_CTRL_PSIS] |=> prev_q == $past(filt_q);
   endproperty
   a_cap_filt: assert property (p_cap_filt)
      else $error("previous value not filter output");
   property p_cap_res;
      @(posedge SYS_CLK) disable iff (RST)
      CONV_START && !ctrl_q[`ACT_CTRL_PSIS] |=> prev_q == $past(res_pair);
   endproperty
   a_cap_res: assert property (p_cap_res)
      else $error("previous value not result");
   property p_just;
      @(posedge SYS_CLK) disable iff (RST)
      !ctrl_q[`ACT_CTRL_JUST] |-> res_pair[3:0] == 4'h0
         && res_pair[15:4] == CONV_RESULT;
   endproperty
   a_just: assert property (p_just)
      else $error("result not top aligned");
   property p_sum_up;
      @(posedge SYS_CLK) disable iff (RST)
      ack_d && WB_ADR_I == `ACT_OFS_SUM_UP |=> WB_DAT_O[7:2] == 6'h00;
   endproperty
   a_sum_up: assert property (p_sum_up)
      else $error("upper sum byte high bits not zero");
   property p_tgt_rst;
      @(posedge SYS_CLK) $fell(RST) |-> tgt_q == 16'h0000
         && low_q == 16'h0000;
   endproperty
   a_tgt_rst: assert property (p_tgt_rst)
      else $error("target or limit not zero after reset");
   property p_dev;
      @(posedge SYS_CLK) disable iff (RST)
      calc == ACT_CALC_SECOND ##1 calc == ACT_CALC_SECOND
         |-> dev_q == 16'($past(res_pair) - $past(tgt_q));
   endproperty
   a_dev: assert property (p_dev)
      else $error("deviation wrong");
   property p_flags;
      @(posedge SYS_CLK) disable iff (RST)
      CHECK_STROBE |=> above_q == ($signed($past(dev_q))
         > $signed($past(high_q)))
         && below_q == ($signed($past(dev_q)) < $signed($past(low_q)));
   endproperty
   a_flags: assert property (p_flags)
      else $error("threshold flags wrong");
   property p_irq;
      @(posedge SYS_CLK) disable iff (RST)
      THRESH_IRQ |-> $past(CHECK_STROBE) && $past(tmd) != ACT_TMD_NEVER;
   endproperty
   a_irq: assert property (p_irq)
      else $error("request without selected outcome");
   property p_filt;
      @(posedge SYS_CLK) disable iff (RST)
      LPF_MODE |=> FILTER_OUTPUT == $past(LPF_VALUE);
   endproperty
   a_filt: assert property (p_filt)
      else $error("filter output not low-pass value");
   // Deviation under the first, filter and previous-minus-filter selects
   property p_dev_first;
      @(posedge SYS_CLK) disable iff (RST)
      calc == ACT_CALC_FIRST ##1 calc == ACT_CALC_FIRST
         |-> dev_q == 16'($past(res_pair) - $past(prev_q));
   endproperty
   a_dev_first: assert property (p_dev_first)
      else $error("result minus previous deviation wrong");
   property p_dev_filt;
      @(posedge SYS_CLK) disable iff (RST)
      calc == ACT_CALC_FILT ##1 calc == ACT_CALC_FILT
         |-> dev_q == 16'($past(filt_q) - $past(tgt_q));
   endproperty
   a_dev_filt: assert property (p_dev_filt)
      else $error("filter minus target deviation wrong");
   property p_dev_prevf;
      @(posedge SYS_CLK) disable iff (RST)
      calc == ACT_CALC_PREVF ##1 calc == ACT_CALC_PREVF
         |-> dev_q == 16'($past(prev_q) - $past(filt_q));
   endproperty
   a_dev_prevf: assert property (p_dev_prevf)
      else $error("previous minus filter deviation wrong");
   // Register writes land at the acknowledged edge
   property p_tgt_write;
      @(posedge SYS_CLK) disable iff (RST)
      wr_en && WB_SEL_I[0] && WB_ADR_I == `ACT_OFS_TGT_HI
         |=> tgt_q[15:8] == 8'($past(WB_DAT_I));
   endproperty
   a_tgt_write: assert property (p_tgt_write)
      else $error("target high byte not written");
   property p_sum_write;
      @(posedge SYS_CLK) disable iff (RST)
      wr_en && WB_SEL_I[0] && WB_ADR_I == `ACT_OFS_SUM_LO
         |=> sum_q[7:0] == 8'($past(WB_DAT_I));
   endproperty
   a_sum_write: assert property (p_sum_write)
      else $error("running sum low byte not written");
   // Request and bus handshake
   property p_irq_never;
      @(posedge SYS_CLK) disable iff (RST)
      CHECK_STROBE && tmd == ACT_TMD_NEVER |=> !THRESH_IRQ;
   endproperty
   a_irq_never: assert property (p_irq_never)
      else $error("request raised in never mode");
   property p_ack_pulse;
      @(posedge SYS_CLK) disable iff (RST)
      WB_ACK_O |=> !WB_ACK_O;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("acknowledge longer than one cycle");
   // Cover points for the main scenarios
   c_read: cover property (@(posedge SYS_CLK) WB_ACK_O && !WB_WE_I);
   c_write: cover property (@(posedge SYS_CLK) WB_ACK_O && WB_WE_I);
   c_below: cover property (@(posedge SYS_CLK) below_q && !above_q);
   c_irq: cover property (@(posedge SYS_CLK) THRESH_IRQ);
   c_cap: cover property (@(posedge SYS_CLK) CONV_START
      && ctrl_q[`ACT_CTRL_PSIS]);
endmodule // act_threshold

// [bench/tb.sv]
// Self-checking bench for the threshold back end and its byte registers
// Assumes the design files, package and constants header are compiled first
`timescale 1ns/1ns
`include "act_regs.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
   fail_count++; $display("wrong value at %0t: got %h expected %h", \
   $time, got, exp); end end
module tb
   import act_pkg::*;
;
   logic        SYS_CLK;      // System clock
   logic        RST;          // Async reset
   logic        WB_CYC_I;     // Bus cycle
   logic        WB_STB_I;     // Bus strobe
   logic        WB_WE_I;      // Bus write
   logic [7:0]  WB_ADR_I;     // Bus address
   logic [3:0]  WB_SEL_I;     // Byte enables
   logic [31:0] WB_DAT_I;     // Write data
   logic [31:0] WB_DAT_O;     // Read data
   logic        WB_ACK_O;     // Bus acknowledge
   logic        CONV_START;   // Conversion start pulse
   logic        CHECK_STROBE; // Threshold check pulse
   logic [11:0] CONV_RESULT;  // Conversion result
   logic        LPF_MODE;     // Low-pass mode
   logic [15:0] LPF_VALUE;    // Low-pass output
   logic [2:0]  SHIFT_AMT;    // Sum right shift
   logic        SUM_LOAD;     // Sum load pulse
   logic [17:0] SUM_IN;       // Sum load value
   logic        THRESH_IRQ;   // Threshold request
   logic [15:0] FILTER_OUTPUT;// Filter value
   int          fail_count;   // Mismatches
   int          checks;       // Comparisons made
   int          cycles;       // Timeout counter
   logic [7:0]  rdat;         // Last read byte

   act_threshold dut_u (.SYS_CLK(SYS_CLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
      .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
      .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
      .WB_ACK_O(WB_ACK_O), .CONV_START(CONV_START),
      .CHECK_STROBE(CHECK_STROBE), .CONV_RESULT(CONV_RESULT),
      .LPF_MODE(LPF_MODE), .LPF_VALUE(LPF_VALUE), .SHIFT_AMT(SHIFT_AMT),
      .SUM_LOAD(SUM_LOAD), .SUM_IN(SUM_IN), .THRESH_IRQ(THRESH_IRQ),
      .FILTER_OUTPUT(FILTER_OUTPUT));

   // Free-running 125 MHz clock
   always #4 SYS_CLK = ~SYS_CLK;

   // Hang guard
   always @(posedge SYS_CLK) begin
      cycles++;
      if (cycles >= 8000) begin
         fail_count++;
         print_verdict();
      end
   end

   // Counts, verdict and end of run
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // One classic Wishbone cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] adr,
                     input logic [7:0] d, output logic [7:0] q);
      @(posedge SYS_CLK);
      WB_CYC_I <= 1'b1;
      WB_STB_I <= 1'b1;
      WB_WE_I  <= we;
      WB_ADR_I <= adr;
      WB_SEL_I <= 4'h1;
      WB_DAT_I <= {24'h000000, d};
      // Only the bench timeout ends a wait for ack
      do begin
         @(posedge SYS_CLK);
      end while (WB_ACK_O !== 1'b1);
      q = WB_DAT_O[7:0];
      WB_CYC_I <= 1'b0;
      WB_STB_I <= 1'b0;
      WB_WE_I  <= 1'b0;
      @(posedge SYS_CLK);
   endtask

   // One-cycle pulse on a front-end strobe: 0 start, 1 check, 2 load
   task automatic pulse(input int w);
      @(posedge SYS_CLK);
      case (w)
         0: CONV_START <= 1'b1;
         1: CHECK_STROBE <= 1'b1;
         default: SUM_LOAD <= 1'b1;
      endcase
      @(posedge SYS_CLK);
      {CONV_START, CHECK_STROBE, SUM_LOAD} <= 3'b000;
   endtask

   // Register reset values and an unmapped address
   task automatic t_reset_vals();
      logic [7:0] ofs [6] = '{`ACT_OFS_TGT_HI, `ACT_OFS_TGT_LO,
         `ACT_OFS_LOW_HI, `ACT_OFS_LOW_LO, `ACT_OFS_HIGH_HI,
         `ACT_OFS_HIGH_LO};
      foreach (ofs[i]) begin
         wb(1'b0, ofs[i], 8'h00, rdat);
         `CHK(rdat, 8'h00)
      end
      wb(1'b0, 8'h3c, 8'h00, rdat);
      `CHK(rdat, 8'h00)
   endtask

   // Sum bytes, upper-byte masking and filter output
   task automatic t_sum();
      SUM_IN    <= 18'h23456;
      SHIFT_AMT <= 3'd2;
      pulse(2);
      repeat (3) @(posedge SYS_CLK);
      `CHK(FILTER_OUTPUT, 16'h8d15)
      wb(1'b0, `ACT_OFS_SUM_UP, 8'h00, rdat);
      `CHK(rdat, 8'h02)
      wb(1'b0, `ACT_OFS_SUM_HI, 8'h00, rdat);
      `CHK(rdat, 8'h34)
      wb(1'b0, `ACT_OFS_SUM_LO, 8'h00, rdat);
      `CHK(rdat, 8'h56)
      wb(1'b1, `ACT_OFS_SUM_UP, 8'hff, rdat);
      wb(1'b1, `ACT_OFS_SUM_HI, 8'ha5, rdat);
      wb(1'b1, `ACT_OFS_SUM_LO, 8'h5a, rdat);
      wb(1'b0, `ACT_OFS_SUM_UP, 8'h00, rdat);
      `CHK(rdat, 8'h03)
      wb(1'b0, `ACT_OFS_SUM_HI, 8'h00, rdat);
      `CHK(rdat, 8'ha5)
      wb(1'b0, `ACT_OFS_SUM_LO, 8'h00, rdat);
      `CHK(rdat, 8'h5a)
      repeat (2) @(posedge SYS_CLK);
      `CHK(FILTER_OUTPUT, 16'he956)
      LPF_MODE  <= 1'b1;
      LPF_VALUE <= 16'h1234;
      repeat (3) @(posedge SYS_CLK);
      `CHK(FILTER_OUTPUT, 16'h1234)
   endtask

   // Capture one previous value and compare both bytes
   task automatic prev_case(input logic [7:0] ctl, input logic [15:0] e);
      wb(1'b1, `ACT_OFS_CTRL, ctl, rdat);
      pulse(0);
      wb(1'b0, `ACT_OFS_PREV_HI, 8'h00, rdat);
      `CHK(rdat, e[15:8])
      wb(1'b0, `ACT_OFS_PREV_LO, 8'h00, rdat);
      `CHK(rdat, e[7:0])
   endtask

   // Previous value from filter and from left or right justified result
   task automatic t_prev();
      CONV_RESULT <= 12'habc;
      prev_case(8'h80, 16'h1234);
      wb(1'b1, `ACT_OFS_PREV_HI, 8'h00, rdat);
      wb(1'b0, `ACT_OFS_PREV_HI, 8'h00, rdat);
      `CHK(rdat, 8'h12)
      prev_case(8'h00, 16'habc0);
      prev_case(8'h40, 16'h0abc);
   endtask

   // Deviation, signed flags and every request mode
   task automatic t_thresh();
      logic [15:0] dev;
      logic        a;
      logic        b;
      logic        e;
      wb(1'b1, `ACT_OFS_TGT_HI, 8'h01, rdat);
      wb(1'b1, `ACT_OFS_TGT_LO, 8'h80, rdat);
      wb(1'b1, `ACT_OFS_LOW_HI, 8'hff, rdat);
      wb(1'b1, `ACT_OFS_HIGH_LO, 8'h10, rdat);
      for (int c = 0; c < 3; c++) begin
         a = (c == 2);
         b = (c == 1);
         dev = a ? 16'h0180 : 16'hff80;
         LPF_VALUE <= a ? 16'h0300 : 16'h0100;
         wb(1'b1, `ACT_OFS_LOW_LO, b ? 8'hc0 : 8'h00, rdat);
         for (int t = 0; t < 8; t++) begin
            wb(1'b1, `ACT_OFS_CTRL, {2'b00, 3'd2, t[2:0]}, rdat);
            pulse(1);
            #1;
            case (t)
               0: e = 1'b0;
               1: e = b;
               2: e = !b;
               3: e = a | b;
               4: e = !a && !b;
               5: e = !a;
               6: e = a;
               default: e = 1'b1;
            endcase
            `CHK(THRESH_IRQ, e)
         end
         wb(1'b0, `ACT_OFS_DEV_HI, 8'h00, rdat);
         `CHK(rdat, dev[15:8])
         wb(1'b0, `ACT_OFS_DEV_LO, 8'h00, rdat);
         `CHK(rdat, dev[7:0])
         wb(1'b0, `ACT_OFS_STAT, 8'h00, rdat);
         `CHK(rdat & 8'h60, {1'b0, a, b, 5'h00})
      end
   endtask

   // Deviation under the other selects: target 0180, filter 0300,
   // previous 0abc and result abc as left by the earlier scenarios
   task automatic t_calc();
      logic [7:0]  ctl [3] = '{8'h48, 8'h58, 8'h00};
      logic [15:0] want [3] = '{16'h093c, 16'h07bc, 16'ha104};
      foreach (ctl[i]) begin
         wb(1'b1, `ACT_OFS_CTRL, ctl[i], rdat);
         wb(1'b0, `ACT_OFS_DEV_HI, 8'h00, rdat);
         `CHK(rdat, want[i][15:8])
         wb(1'b0, `ACT_OFS_DEV_LO, 8'h00, rdat);
         `CHK(rdat, want[i][7:0])
      end
   endtask

   // Main sequence
   initial begin
      SYS_CLK = 1'b0;
      RST = 1'b1;
      {WB_CYC_I, WB_STB_I, WB_WE_I} = 3'b000;
      WB_ADR_I = 8'h00;
      WB_SEL_I = 4'h0;
      WB_DAT_I = 32'h00000000;
      {CONV_START, CHECK_STROBE, SUM_LOAD, LPF_MODE} = 4'h0;
      CONV_RESULT = 12'h000;
      LPF_VALUE = 16'h0000;
      SHIFT_AMT = 3'd0;
      SUM_IN = 18'h00000;
      fail_count = 0;
      checks = 0;
      cycles = 0;
      repeat (3) @(posedge SYS_CLK);
      RST <= 1'b0;
      t_reset_vals();
      t_sum();
      t_prev();
      t_thresh();
      t_calc();
      print_verdict();
   end
endmodule // tb
